// File: rtl/snvfe_pkg.sv
// Package: shared constants for the SPI nvSRAM front end
package snvfe_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_STORE = 8'h3C;
  localparam logic [7:0] OP_RECALL = 8'h60;
  localparam logic [7:0] OP_ASENB = 8'h59;
  localparam logic [7:0] OP_ASDISB = 8'h19;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WRSN = 8'hC2;
  localparam logic [7:0] OP_RDSN = 8'hC3;
  localparam logic [7:0] OP_RDID = 8'h9F;
  // ==========================================================
  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_WEN = 1;
  localparam int ST_BPL = 2;
  localparam int ST_BPH = 3;
  localparam int ST_PPE = 7;
  localparam logic [7:0] ST_NV_MASK = 8'h8C;
  localparam logic [7:0] ST_RESET = 8'h00;
  // ==========================================================
  // Address
  localparam int ADDR_BITS = 13;
  // ==========================================================
  // Timing, clock 10 MHz
  localparam int CLK_NS = 100;
  localparam int POWERUP_RESTORE_TIME_NS = 20000;
  localparam int STANDBY_ENTRY_TIME_NS = 100000;
  localparam int WRITE_FINISH_NS = 25000;
  localparam int SAVE_TIME_NS = 80000;
  localparam int RESTORE_SW_NS = 30000;
  localparam int RESTORE_CYC = (POWERUP_RESTORE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int STANDBY_CYC = (STANDBY_ENTRY_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int FINISH_CYC = WRITE_FINISH_NS / CLK_NS;
  localparam int SAVE_CYC = (SAVE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int SWREST_CYC = (RESTORE_SW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOST_DIV = 4;
endpackage

// File: rtl/snvfe_if.sv
// Interface: SPI link between master and nvSRAM front end
interface snvfe_if;
  logic sel_n;
  logic sck;
  logic si;
  logic so_o;
  logic so_oe;
  logic so;
  assign so = so_oe ? so_o : 1'b1;
  modport dev (input sel_n, input sck, input si, output so_o, output so_oe);
  modport host (output sel_n, output sck, output si, input so);
endinterface

// File: rtl/snvfe_dev.sv
// Device end: SPI slave front end of a serial nvSRAM
// Behaviour
// - sample SI on rise, drive SO on fall
// - first byte after select is opcode
// - one opcode per select period
// - master frames each operation with select
// - deselected: ignore SI, SO high impedance
// - all bytes shifted MSB first
// - two address bytes, low 13 used
// - master sends unused address bits zero
// - invalid opcode ignored until next select
// - clock level at select picks mode
// - mode 3 first rise after toggle
// - master idles clock per mode
// - eight-bit status register
// - power-up restore blocks memory access
// - after power-up WEL zero, not held
// - protect bits nonvolatile across power
// - power fail: finish received write only
// - after grace, save if written
// - selected means active power mode
// - standby after delay or NV cycle
// - fourteen opcodes, others invalid
// - busy bit 0 during save, STORE or RECALL, clear during power-up restore
//
// The register addresses and the plain strobed port were chosen for this implementation.
module snvfe_dev
  import snvfe_pkg::*;
#(
  parameter int RESTORE_CYCLES = RESTORE_CYC,
  parameter int STANDBY_CYCLES = STANDBY_CYC,
  parameter int SAVE_CYCLES = SAVE_CYC
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, low
  snvfe_if.dev spi, // SPI link
  input wire logic supply_ok, // Supply above threshold
  output logic [7:0] opcode, // Captured opcode
  output logic opcode_valid, // Opcode accepted pulse
  output logic [ADDR_BITS-1:0] mem_addr, // Memory address
  output logic [7:0] wr_data, // Byte to write
  output logic wr_strobe, // Write pulse
  input wire logic [7:0] rd_data, // Read byte from array
  output logic rd_strobe, // Read request pulse
  output logic [7:0] status, // Status register
  output logic mem_blocked, // Memory access inhibited
  output logic active_mode, // Active power mode
  output logic saving // Power-fail save cycle running, not STORE
);
  typedef enum {SN_OP, SN_ADDR, SN_DATA, SN_IGNORE, SN_DONE} snvfe_ph_t;
  typedef enum {SN_RESTORE, SN_RUN, SN_GRACE, SN_SAVE, SN_OFF} snvfe_pw_t;

  // ==========================================================
  // Synchronisers
  logic [1:0] sel_s_q, sck_s_q, si_s_q, sup_s_q;
  logic sel_q, sck_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_s_q <= 2'h3;
      sck_s_q <= 2'h0;
      si_s_q <= 2'h0;
      sup_s_q <= 2'h0;
      sel_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      sel_s_q <= {sel_s_q[0], spi.sel_n};
      sck_s_q <= {sck_s_q[0], spi.sck};
      si_s_q <= {si_s_q[0], spi.si};
      sup_s_q <= {sup_s_q[0], supply_ok};
      sel_q <= sel_s_q[1];
      sck_q <= sck_s_q[1];
    end
  end
  wire logic sel_n = sel_s_q[1];
  wire logic sck = sck_s_q[1];
  wire logic sup = sup_s_q[1];
  wire logic sel_fall = sel_q && !sel_n;
  wire logic sck_rise = !sck_q && sck && !sel_n;
  wire logic sck_fall = sck_q && !sck && !sel_n;

  // ==========================================================
  // Serial engine state
  snvfe_ph_t ph_q, ph_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, op_q, op_d;
  logic [15:0] addr_q, addr_d;
  logic abyte_q, abyte_d, so_q, so_d, oe_q, oe_d;
  logic wel_q, wel_d, wrote_q, wrote_d, last_q, last_d;
  logic [7:0] nv_q, nv_d;
  logic opv, wrs, rds, sw_save, sw_rest;
  snvfe_pw_t pw_q, pw_d;
  logic [31:0] cnt_q, cnt_d, sb_q, sb_d;
  logic busy, rd_pend_q;

  function automatic logic op_known(input logic [7:0] o);
    unique case (o)
      OP_RDSR, OP_WRSR, OP_WREN, OP_WRDI, OP_READ, OP_WRITE, OP_STORE,
      OP_RECALL, OP_ASENB, OP_ASDISB, OP_SLEEP, OP_WRSN, OP_RDSN,
      OP_RDID: op_known = 1'b1;
      default: op_known = 1'b0;
    endcase
  endfunction

  assign busy = (pw_q == SN_SAVE) || (cnt_q != 0 && pw_q == SN_RUN);
  wire logic [7:0] st = {nv_q[ST_PPE], 3'h0, nv_q[ST_BPH], nv_q[ST_BPL],
    wel_q, busy};
  wire logic live = (pw_q == SN_RUN) && !busy;
  wire logic [7:0] nsh = {sh_q[6:0], si_s_q[1]};

  always_comb begin
    ph_d = ph_q; bit_d = bit_q; sh_d = sh_q; tx_d = tx_q; op_d = op_q;
    addr_d = addr_q; abyte_d = abyte_q; so_d = so_q; oe_d = oe_q;
    wel_d = wel_q; wrote_d = wrote_q; nv_d = nv_q; last_d = 1'b0;
    opv = 1'b0; wrs = 1'b0; rds = 1'b0; sw_save = 1'b0; sw_rest = 1'b0;
    if (sel_n) begin
      oe_d = 1'b0;
      ph_d = SN_DONE;
    end else if (sel_fall) begin
      // Mode is implicit: a high idle clock gives a fall first
      ph_d = SN_OP; bit_d = 3'h0; abyte_d = 1'b0; oe_d = 1'b0;
    end else if (sck_rise) begin
      sh_d = nsh;
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        unique case (ph_q)
          SN_OP: begin
            op_d = nsh;
            if (!op_known(nsh) || !sup) ph_d = SN_IGNORE;
            else begin
              opv = 1'b1;
              ph_d = SN_DONE;
              unique case (nsh)
                OP_READ, OP_WRITE: ph_d = SN_ADDR;
                OP_RDSR: begin ph_d = SN_DATA; tx_d = st; end
                OP_WRSR: ph_d = SN_DATA;
                OP_WREN: wel_d = 1'b1;
                OP_WRDI: wel_d = 1'b0;
                OP_STORE: sw_save = live;
                OP_RECALL: sw_rest = live;
                default: ph_d = SN_DONE;
              endcase
            end
          end
          SN_ADDR: begin
            addr_d = {addr_q[7:0], nsh};
            abyte_d = 1'b1;
            if (abyte_q) begin
              ph_d = SN_DATA;
              if (op_q == OP_READ) rds = live;
            end
          end
          SN_DATA: begin
            if (op_q == OP_WRITE && wel_q && live) begin
              wrs = 1'b1; wrote_d = 1'b1; last_d = 1'b1;
            end
            if (op_q == OP_WRSR && wel_q) nv_d = nsh & ST_NV_MASK;
            if (op_q == OP_RDSR) tx_d = st;
            if (op_q == OP_READ || op_q == OP_WRITE) begin
              addr_d = {3'h0, addr_q[ADDR_BITS-1:0] + 13'h1};
              if (op_q == OP_READ) rds = live;
            end
          end
          default: ph_d = ph_q;
        endcase
      end
    end else if (sck_fall && ph_q == SN_DATA &&
      (op_q == OP_READ || op_q == OP_RDSR)) begin
      oe_d = 1'b1;
      so_d = tx_q[7];
      tx_d = {tx_q[6:0], 1'b0};
    end
    if (rd_pend_q) tx_d = rd_data;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_pend_q <= 1'b0;
    else rd_pend_q <= rds;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= SN_DONE; bit_q <= 3'h0; sh_q <= 8'h00; tx_q <= 8'h00;
      op_q <= 8'h00; addr_q <= 16'h0000; abyte_q <= 1'b0; so_q <= 1'b0;
      oe_q <= 1'b0; wel_q <= 1'b0; wrote_q <= 1'b0; nv_q <= ST_RESET;
      last_q <= 1'b0;
    end else begin
      ph_q <= ph_d; bit_q <= bit_d; sh_q <= sh_d; tx_q <= tx_d;
      op_q <= op_d; addr_q <= addr_d; abyte_q <= abyte_d; so_q <= so_d;
      oe_q <= oe_d; wel_q <= (pw_q == SN_RESTORE) ? 1'b0 : wel_d;
      wrote_q <= (pw_q == SN_SAVE || sw_rest) ? 1'b0 : wrote_d;
      nv_q <= nv_d; last_q <= last_d;
    end
  end

  // ==========================================================
  // Power sequencing
  always_comb begin
    pw_d = pw_q; cnt_d = cnt_q == 0 ? 0 : cnt_q - 1;
    sb_d = sel_n ? (sb_q == 0 ? 0 : sb_q - 1) : STANDBY_CYCLES;
    unique case (pw_q)
      SN_RESTORE: if (cnt_q <= 1) pw_d = SN_RUN;
      SN_RUN: begin
        if (sw_save) cnt_d = SAVE_CYCLES;
        if (sw_rest) cnt_d = SWREST_CYC;
        if (!sup) begin pw_d = SN_GRACE; cnt_d = FINISH_CYC; end
      end
      SN_GRACE: if (cnt_q <= 1) begin
        pw_d = wrote_q ? SN_SAVE : SN_OFF;
        cnt_d = SAVE_CYCLES;
      end
      SN_SAVE: if (cnt_q <= 1) pw_d = SN_OFF;
      SN_OFF: if (sup) begin pw_d = SN_RESTORE; cnt_d = RESTORE_CYCLES; end
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pw_q <= SN_RESTORE; cnt_q <= RESTORE_CYCLES; sb_q <= STANDBY_CYCLES;
    end else begin
      pw_q <= pw_d; cnt_q <= cnt_d; sb_q <= sb_d;
    end
  end

  assign spi.so_o = so_q;
  assign spi.so_oe = oe_q && !sel_n;
  assign opcode = op_q;
  assign opcode_valid = opv;
  assign mem_addr = addr_q[ADDR_BITS-1:0];
  assign wr_data = sh_d;
  assign wr_strobe = wrs;
  assign rd_strobe = rds;
  assign status = st;
  assign mem_blocked = !live;
  assign active_mode = !sel_n || sb_q != 0 || busy;
  assign saving = pw_q == SN_SAVE;
endmodule

// File: rtl/snvfe_host.sv
// Master end: simple SPI master for the nvSRAM link
module snvfe_host
  import snvfe_pkg::*;
#(
  parameter int DIV = HOST_DIV,
  parameter bit MODE3 = 1'b0
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, low
  snvfe_if.host spi, // SPI link
  input wire logic start, // Begin a frame pulse
  input wire logic [5:0] nbytes, // Bytes in frame
  input wire logic [7:0] tx_byte, // Next byte to send
  output logic tx_take, // Byte taken pulse
  output logic [7:0] rx_byte, // Byte received
  output logic rx_valid, // Received pulse
  output logic busy // Frame in progress
);
  typedef enum {SH_IDLE, SH_LOW, SH_HIGH, SH_END} snvfe_hs_t;
  snvfe_hs_t st_q, st_d;
  logic [7:0] div_q, div_d, sh_q, sh_d, rx_q, rx_d;
  logic [2:0] bit_q, bit_d;
  logic [5:0] left_q, left_d;
  logic sel_q, sel_d, sck_q, sck_d, take, rxv;
  logic [1:0] so_s_q;
  always_comb begin
    st_d = st_q; div_d = div_q == 8'h00 ? 8'h00 : div_q - 8'h1; sh_d = sh_q;
    rx_d = rx_q; bit_d = bit_q; left_d = left_q; sel_d = sel_q;
    sck_d = sck_q; take = 1'b0; rxv = 1'b0;
    unique case (st_q)
      SH_IDLE: begin
        sck_d = MODE3; sel_d = 1'b1;
        if (start && nbytes != 0) begin
          sel_d = 1'b0; sh_d = tx_byte; take = 1'b1; left_d = nbytes;
          bit_d = 3'h0; div_d = 8'(DIV); st_d = SH_LOW;
        end
      end
      SH_LOW: if (div_q == 0) begin
        sck_d = 1'b1; div_d = 8'(DIV); st_d = SH_HIGH;
      end else if (div_q == 8'(DIV)) sck_d = 1'b0;
      // Sample one clock after the rise: the answer lags the fall by five
      SH_HIGH: if (div_q == 8'(DIV)) begin
        rx_d = {rx_q[6:0], so_s_q[1]};
      end else if (div_q == 0) begin
        div_d = 8'(DIV); bit_d = bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          rxv = 1'b1; left_d = left_q - 6'h1;
          if (left_q == 6'h1) st_d = SH_END;
          else begin sh_d = tx_byte; take = 1'b1; st_d = SH_LOW; end
        end else begin
          sh_d = {sh_q[6:0], 1'b0}; st_d = SH_LOW;
        end
        sck_d = (bit_q == 3'h7 && left_q == 6'h1) ? MODE3 : 1'b0;
      end
      SH_END: if (div_q == 0) begin sel_d = 1'b1; st_d = SH_IDLE; end
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SH_IDLE; div_q <= 8'h00; sh_q <= 8'h00; rx_q <= 8'h00;
      bit_q <= 3'h0; left_q <= 6'h00; sel_q <= 1'b1; sck_q <= 1'b0;
      so_s_q <= 2'h0;
    end else begin
      st_q <= st_d; div_q <= div_d; sh_q <= sh_d; rx_q <= rx_d;
      bit_q <= bit_d; left_q <= left_d; sel_q <= sel_d; sck_q <= sck_d;
      so_s_q <= {so_s_q[0], spi.so};
    end
  end
  assign spi.sel_n = sel_q;
  assign spi.sck = sck_q;
  assign spi.si = sh_q[7]; // zeros come from tx_byte
  assign tx_take = take;
  assign rx_byte = rx_q;
  assign rx_valid = rxv;
  assign busy = st_q != SH_IDLE;
endmodule

// File: dv/snvfe_monitor.sv
// Checker: wire rules on the SPI link between both ends
module snvfe_monitor
  import snvfe_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, low
  input wire logic sel_n, // Select, low active
  input wire logic sck, // Serial clock
  input wire logic si, // Serial in
  input wire logic so_o, // Device data out
  input wire logic so_oe, // Device drive enable
  input wire logic so // Resolved serial out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sck_q, sck_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic bad;
  // ==========================================
  // Opcode tracker
  always_comb begin
    sck_d = sck;
    cnt_d = sel_n ? 4'h0 : cnt_q;
    sh_d = sh_q;
    if (!sel_n && sck && !sck_q && cnt_q < 4'h8) begin
      cnt_d = cnt_q + 4'h1;
      sh_d = {sh_q[6:0], si};
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
    end else begin
      sck_q <= sck_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
    end
  end
  assign bad = cnt_q == 4'h8 && !(sh_q inside {OP_RDSR, OP_WRSR,
    OP_WREN, OP_WRDI, OP_READ, OP_WRITE, OP_STORE, OP_RECALL, OP_ASENB,
    OP_ASDISB, OP_SLEEP, OP_WRSN, OP_RDSN, OP_RDID});
  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Six cycles covers the device's input synchroniser
  a_desel_so_off: assert property (sel_n [*6] |-> !so_oe)
    else $error("output driven while deselected");
  a_oe_needs_sel: assert property ($rose(so_oe) |-> !sel_n)
    else $error("output enabled without select");
  a_opcode_quiet: assert property (!sel_n && cnt_q < 4'h8 |-> !so_oe)
    else $error("output driven during opcode");
  a_invalid_quiet: assert property (!sel_n && bad |-> !so_oe)
    else $error("output driven after invalid opcode");
  a_so_moves_low: assert property (so_oe && $changed(so_o) |-> !sck)
    else $error("output changed while clock high");
  a_si_hold_high: assert property (
    !sel_n && sck && $past(sck) |-> $stable(si))
    else $error("input changed while clock high");
  a_idle_clock: assert property (sel_n && $past(sel_n) |-> $stable(sck))
    else $error("clock moved between frames");
  a_select_low_clk: assert property ($fell(sel_n) |-> !sck)
    else $error("mode 0 select with clock high");
  c_read_out: cover property ($rose(so_oe));
  c_invalid: cover property (!sel_n && bad);
  c_long_frame: cover property ($rose(sel_n) && cnt_q == 4'h8 && so);
endmodule

// File: dv/tb.sv
// Testbench: both SPI ends joined, plus a bench-driven mode 3 link
module tb;
  import snvfe_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RC = 10;
  localparam int SC = 20;
  localparam int VC = 10;
  logic clk, rst_n, supply_ok, start, tx_take, rx_valid, busy;
  logic opcode_valid, wr_strobe, mem_blocked, active_mode, saving;
  logic ws2, save_seen, act_mid, busy_seen;
  logic [5:0] nbytes;
  logic [7:0] tx_byte, rx_byte, opcode, wr_data, status, wd2, rx2;
  logic [12:0] mem_addr, ma2, w2_addr;
  logic [7:0] w2_data;
  logic [7:0] txq[$], rxq[$];
  logic [20:0] wq[$];
  int errors, samples_checked, vcnt, cycles, n;
  snvfe_if lnk ();
  snvfe_if bb ();
  snvfe_host i_snvfe_host (.clk, .rst_n, .spi(lnk.host), .start, .nbytes,
    .tx_byte, .tx_take, .rx_byte, .rx_valid, .busy);
  snvfe_dev #(.RESTORE_CYCLES(RC), .STANDBY_CYCLES(SC), .SAVE_CYCLES(VC))
    i_snvfe_dev (.clk, .rst_n, .spi(lnk.dev), .supply_ok, .opcode,
    .opcode_valid, .mem_addr, .wr_data, .wr_strobe,
    .rd_data(mem_addr[7:0] ^ 8'hC3), .rd_strobe(), .status, .mem_blocked,
    .active_mode, .saving);
  snvfe_dev #(.RESTORE_CYCLES(RC), .STANDBY_CYCLES(SC), .SAVE_CYCLES(VC))
    i_snvfe_dev_m3 (.clk, .rst_n, .spi(bb.dev), .supply_ok(1'b1),
    .opcode(), .opcode_valid(), .mem_addr(ma2), .wr_data(wd2),
    .wr_strobe(ws2), .rd_data(ma2[7:0] ^ 8'hC3), .rd_strobe(), .status(),
    .mem_blocked(), .active_mode(), .saving());
  snvfe_monitor i_snvfe_monitor (.clk, .rst_n, .sel_n(lnk.sel_n),
    .sck(lnk.sck), .si(lnk.si), .so_o(lnk.so_o), .so_oe(lnk.so_oe),
    .so(lnk.so));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================
  // Observers and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (opcode_valid === 1'b1) vcnt <= vcnt + 1;
    if (wr_strobe === 1'b1) wq.push_back({mem_addr, wr_data});
    if (ws2 === 1'b1) {w2_addr, w2_data} <= {ma2, wd2};
    if (saving === 1'b1) save_seen <= 1'b1;
    if (status[0] === 1'b1) busy_seen <= 1'b1;
    if (cycles == 60000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic frame();
    int k, t;
    k = 1;
    rxq.delete();
    tx_byte <= txq[0];
    nbytes <= 6'(txq.size());
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    // First byte was taken at this edge, so offer the second now
    if (txq.size() > 1) tx_byte <= txq[1];
    for (t = 0; t < 3000; t++) begin
      @(posedge clk);
      if (t == 30) act_mid = active_mode;
      if (rx_valid === 1'b1) rxq.push_back(rx_byte);
      if (tx_take === 1'b1 && ++k < txq.size()) tx_byte <= txq[k];
      if (t > 2 && busy === 1'b0) break;
    end
    idle(8);
  endtask
  // Mode 3 master: clock idles high, its phase unrelated to clk
  task automatic bbf(input logic [31:0] v, input int nb);
    int i;
    #37 bb.sel_n = 1'b0;
    #400;
    for (i = nb * 8 - 1; i >= 0; i--) begin
      bb.sck = 1'b0;
      bb.si = v[i];
      #400 bb.sck = 1'b1;
      rx2 = {rx2[6:0], bb.so};
      #400;
    end
    bb.sel_n = 1'b1;
    bb.si = ~bb.si;
    #800 bb.si = ~bb.si;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_power_up();
    check(mem_blocked, 1);
    check(status[1], 0);
    check(lnk.so_oe, 0);
    idle(RC + SC + 10);
    check(mem_blocked, 0);
    check(active_mode, 0);
  endtask
  task automatic t_write_wrap();
    wq.delete();
    txq = '{OP_WREN};
    frame();
    check(status[1], 1);
    txq = '{OP_WRITE, 8'h1F, 8'hFF, 8'h5A, 8'hA5};
    frame();
    check(act_mid, 1);
    check(opcode, OP_WRITE);
    check(wq[0], {13'h1FFF, 8'h5A});
    check(wq[1], {13'h0000, 8'hA5});
    check(active_mode, 1);
    idle(SC + 10);
    check(active_mode, 0);
  endtask
  task automatic t_read();
    txq = '{OP_READ, 8'h00, 8'h10, 8'h00, 8'h00};
    frame();
    check(rxq[3], 8'hD3);
    check(rxq[4], 8'hD2);
  endtask
  task automatic t_one_op();
    txq = '{OP_WREN, OP_WRDI};
    frame();
    check(status[1], 1);
    txq = '{OP_WRDI};
    frame();
    check(status[1], 0);
  endtask
  task automatic t_invalid();
    logic [7:0] bad[6] = '{8'h1E, 8'h09, 8'h0B, 8'hC9, 8'h99, 8'hFF};
    foreach (bad[i]) begin
      n = vcnt;
      txq = '{bad[i], OP_READ, 8'h00, 8'h10, 8'h00};
      frame();
      check(vcnt - n, 0);
      check(rxq[4], 8'hFF);
    end
  endtask
  task automatic t_mode3();
    bbf(32'h06, 1);
    bbf(32'h02E00577, 4);
    check(w2_addr, 13'h0005);
    check(w2_data, 8'h77);
    bbf(32'h031FFE00, 4);
    check(rx2, 8'h3D);
    check(bb.so_oe, 0);
  endtask
  task automatic t_power_fail();
    txq = '{OP_WREN};
    frame();
    txq = '{OP_WRITE, 8'h00, 8'h20, 8'h11};
    frame();
    save_seen = 1'b0;
    supply_ok <= 1'b0;
    idle(FINISH_CYC + 40);
    check(save_seen, 1);
    check(mem_blocked, 1);
    supply_ok <= 1'b1;
    idle(RC + 20);
    save_seen = 1'b0;
    supply_ok <= 1'b0;
    idle(4);
    n = vcnt;
    txq = '{OP_WREN};
    frame();
    check(vcnt - n, 0);
    idle(FINISH_CYC + 40);
    check(save_seen, 0);
    supply_ok <= 1'b1;
    idle(RC + 20);
  endtask
  task automatic t_all_ops();
    logic [7:0] ops[14] = '{OP_RDSR, OP_WRSR, OP_WREN, OP_WRDI, OP_READ,
      OP_WRITE, OP_RECALL, OP_ASENB, OP_ASDISB, OP_WRSN, OP_RDSN, OP_RDID,
      OP_STORE, OP_SLEEP};
    foreach (ops[i]) begin
      n = vcnt;
      busy_seen = 1'b0;
      txq = '{ops[i]};
      frame();
      check(vcnt - n, 1);
      check(opcode, ops[i]);
      if (ops[i] == OP_RECALL) begin
        check(status[0], 1);
        idle(SWREST_CYC);
      end
      if (ops[i] == OP_STORE) check(busy_seen, 1);
    end
  endtask
  initial begin
    rst_n = 1'b0;
    supply_ok = 1'b1;
    start = 1'b0;
    nbytes = 6'h00;
    tx_byte = 8'h00;
    {errors, samples_checked, vcnt, cycles} = '0;
    save_seen = 1'b0;
    bb.sel_n = 1'b1;
    bb.sck = 1'b1;
    bb.si = 1'b0;
    idle(8);
    rst_n <= 1'b1;
    idle(1);
    t_power_up();
    t_write_wrap();
    t_read();
    t_one_op();
    t_invalid();
    t_mode3();
    t_power_fail();
    t_all_ops();
    report_and_stop();
  end
endmodule
